// [include/mpt_pkg.sv]
/*
 * shared constants of the pwm timer: register offsets, field positions,
 * reset values and bus response codes.
 * assumes a 32-bit axi4-lite register bus with an 8-bit byte address.
 */
`default_nettype none
package mpt_pkg;
	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int DW = 32; // data and counter width
	localparam int ADDR_W = 8; // byte address width
	localparam int NUM_MATCH = 7; // match registers
	localparam int NUM_OUT = 6; // pwm output pins
	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00; // run, counter reset, pwm mode
	localparam logic [7:0] OFF_COUNT = 8'h04; // counter value, read only
	localparam logic [7:0] OFF_PRESC = 8'h08; // prescale limit
	localparam logic [7:0] OFF_PCOUNT = 8'h0c; // prescale count, read only
	localparam logic [7:0] OFF_MCTRL = 8'h10; // per-match reset/stop
	localparam logic [7:0] OFF_RELEASE = 8'h14; // write one to release
	localparam logic [7:0] OFF_OUTCTRL = 8'h18; // edge select, enables
	localparam logic [7:0] OFF_INT_STAT = 8'h1c; // sticky match flags
	localparam logic [7:0] OFF_INT_CLR = 8'h20; // write one to clear
	localparam logic [7:0] OFF_INT_EN = 8'h24; // interrupt enables
	localparam logic [7:0] OFF_MATCH0 = 8'h40; // cycle_match_register
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CTRL_RUN = 0; // counter and prescaler enable
	localparam int CTRL_CRST = 1; // hold counter and prescaler at zero
	localparam int CTRL_PWM = 2; // pwm mode enable
	localparam int CTRL_W = 3;
	localparam int MC_RST = 0; // reset counter on match
	localparam int MC_STOP = 1; // stop counter on match
	localparam int MC_W = 2; // bits per match in mctrl
	localparam int OC_DBL = 0; // bits 5:0, double-edge select out1..6
	localparam int OC_EN = 8; // bits 13:8, output enable out1..6
	// ------------------------------------------------------------
	// reset values and responses
	// ------------------------------------------------------------
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// [rtl/mpt_prescale.sv]
/*
 * prescaler: counts clock cycles up to a limit and gives one tick per
 * wrap, which advances the main counter.
 * assumes run, clear and limit come from registers on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
module mpt_prescale #(
	parameter int W = 32
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic run,
	input wire logic clear,
	input wire logic [W-1:0] limit,
	output logic tick,
	output logic [W-1:0] pcount
);
	logic [W-1:0] pc_reg; // prescale count
	logic [W-1:0] pc_next;

	// ------------------------------------------------------------
	// tick and next count
	// ------------------------------------------------------------
	// a limit lowered below the count still wraps at once
	assign tick = run && !clear && (pc_reg >= limit);
	assign pcount = pc_reg;

	// next prescale count
	always_comb begin
		pc_next = pc_reg;
		if (clear) begin
			pc_next = '0;
		end else if (tick) begin
			pc_next = '0;
		end else if (run) begin
			pc_next = pc_reg + {{(W-1){1'b0}}, 1'b1};
		end
	end

	// register, zero after reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pc_reg <= '0;
		end else begin
			pc_reg <= pc_next;
		end
	end
endmodule
`default_nettype wire

// [rtl/mpt_pwm_chan.sv]
/*
 * one pwm output: set by its set event, cleared by its clear event,
 * clear winning when both fall in one cycle; low while disabled.
 * assumes one-cycle event pulses from the match compare.
 */
`timescale 1ns/1ns
`default_nettype none
module mpt_pwm_chan (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic enable,
	input wire logic set_evt,
	input wire logic clr_evt,
	output logic pin
);
	logic out_reg; // pin level
	logic out_next;

	// ------------------------------------------------------------
	// output level
	// ------------------------------------------------------------
	// clear wins, so equal set and clear positions give constant low
	always_comb begin
		out_next = out_reg;
		if (!enable) begin
			out_next = 1'b0;
		end else if (clr_evt) begin
			out_next = 1'b0;
		end else if (set_evt) begin
			out_next = 1'b1;
		end
	end

	// register, low after reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_reg <= 1'b0;
		end else begin
			out_reg <= out_next;
		end
	end

	assign pin = out_reg;
endmodule
`default_nettype wire

// [rtl/mpt_top.sv]
/*
 * pwm timer: 32-bit counter behind a 32-bit prescaler, seven match
 * registers with held and active copies, six pwm outputs, match flags
 * with an interrupt, all behind an axi4-lite slave.
 * assumes one clock aclk, synchronous active-low reset aresetn, and an
 * axi4-lite master that keeps valid and payload stable until taken.
 */
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - 32-bit counter, 32-bit prescaler, seven matches
// - in pwm mode, cycle match resets counter, sets period
// - single-edge outputs rise at cycle start
// - one match places each single-edge fall
// - two matches place double-edge rise, fall
// - rise first gives high pulse, else low
// - double edges anywhere within the cycle
// - six single, three double, or mixed
// - per match: interrupt, stop, reset, continue
// - in pwm mode, new match values wait for release
// - period and width in whole counts
// - without pwm mode, plain timer, outputs low
module mpt_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [mpt_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [mpt_pkg::DW-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [mpt_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [mpt_pkg::DW-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [mpt_pkg::NUM_OUT-1:0] pwm_out,
	output logic irq
);
	import mpt_pkg::*;

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	// bus state
	logic aw_full_reg, aw_full_next; // write address held
	logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
	logic w_full_reg, w_full_next; // write data held
	logic [DW-1:0] w_data_reg, w_data_next;
	logic [3:0] w_strb_reg, w_strb_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic rvalid_reg, rvalid_next;
	logic [1:0] rresp_reg, rresp_next;
	logic [DW-1:0] rdata_reg, rdata_next;
	// software registers
	logic [CTRL_W-1:0] ctrl_reg, ctrl_next; // run, crst, pwm
	logic [DW-1:0] presc_reg, presc_next; // prescale limit
	logic [MC_W*NUM_MATCH-1:0] mctrl_reg, mctrl_next; // reset/stop
	logic [NUM_MATCH-1:0] rel_reg, rel_next; // released, not yet copied
	logic [NUM_OUT-1:0] dbl_reg, dbl_next; // double-edge select
	logic [NUM_OUT-1:0] oen_reg, oen_next; // output enables
	logic [NUM_MATCH-1:0] stat_reg, stat_next; // sticky match flags
	logic [NUM_MATCH-1:0] ien_reg, ien_next; // interrupt enables
	logic [DW-1:0] hold_reg [NUM_MATCH]; // values written by software
	logic [DW-1:0] hold_next [NUM_MATCH];
	// timer state
	logic [DW-1:0] count_reg, count_next; // main counter
	logic [DW-1:0] act_reg [NUM_MATCH]; // values in use by compare
	logic [DW-1:0] act_next [NUM_MATCH];
	// timer events
	logic tick; // prescaler wrap
	logic [DW-1:0] pcount; // prescale count
	logic [NUM_MATCH-1:0] hit; // match this tick
	logic [NUM_MATCH-1:0] rst_en; // match resets counter
	logic [NUM_MATCH-1:0] stop_en; // match stops counter
	logic any_rst, any_stop, cycle_wrap;
	logic pwm_on, crst;
	logic do_wr; // write executes this cycle
	logic wr_map; // write address is mapped
	logic [DW-1:0] rd_word; // read mux result
	logic rd_map; // read address is mapped
	logic m_wr; // write targets a match register
	logic m_rd;
	logic [2:0] m_widx; // match index of the write
	logic [2:0] m_ridx;

	assign pwm_on = ctrl_reg[CTRL_PWM];
	assign crst = ctrl_reg[CTRL_CRST];

	// merge write data into an old word under the byte strobes
	function automatic logic [DW-1:0] wmerge(
		input logic [DW-1:0] old,
		input logic [DW-1:0] dat,
		input logic [3:0] strb
	);
		logic [DW-1:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = dat[8*b +: 8];
			end
		end
		return r;
	endfunction

	// ------------------------------------------------------------
	// axi4-lite handshake
	// ------------------------------------------------------------
	assign s_axi_awready = !aw_full_reg;
	assign s_axi_wready = !w_full_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;
	assign do_wr = aw_full_reg && w_full_reg && !bvalid_reg;

	// match window decode, offsets 0x40 to 0x58
	assign m_widx = aw_addr_reg[4:2];
	assign m_ridx = s_axi_araddr[4:2];
	assign m_wr = (aw_addr_reg[7:5] == OFF_MATCH0[7:5]) && (m_widx < 3'h7);
	assign m_rd = (s_axi_araddr[7:5] == OFF_MATCH0[7:5]) && (m_ridx < 3'h7);

	// address and data may arrive in either order; response after both
	always_comb begin
		aw_full_next = aw_full_reg;
		aw_addr_next = aw_addr_reg;
		w_full_next = w_full_reg;
		w_data_next = w_data_reg;
		w_strb_next = w_strb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		// take write address
		if (s_axi_awvalid && !aw_full_reg) begin
			aw_full_next = 1'b1;
			aw_addr_next = s_axi_awaddr;
		end
		// take write data
		if (s_axi_wvalid && !w_full_reg) begin
			w_full_next = 1'b1;
			w_data_next = s_axi_wdata;
			w_strb_next = s_axi_wstrb;
		end
		// response taken
		if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		// execute write, unmapped answers slverr
		if (do_wr) begin
			aw_full_next = 1'b0;
			w_full_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = wr_map ? RESP_OKAY : RESP_SLVERR;
		end
		// read data taken
		if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
		// take read address, answer next cycle
		if (s_axi_arvalid && !rvalid_reg) begin
			rvalid_next = 1'b1;
			rdata_next = rd_word;
			rresp_next = rd_map ? RESP_OKAY : RESP_SLVERR;
		end
	end

	// register bus state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_reg <= 1'b0;
			aw_addr_reg <= '0;
			w_full_reg <= 1'b0;
			w_data_reg <= RST_WORD;
			w_strb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			rvalid_reg <= 1'b0;
			rresp_reg <= RESP_OKAY;
			rdata_reg <= RST_WORD;
		end else begin
			aw_full_reg <= aw_full_next;
			aw_addr_reg <= aw_addr_next;
			w_full_reg <= w_full_next;
			w_data_reg <= w_data_next;
			w_strb_reg <= w_strb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
		end
	end

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	always_comb begin
		rd_word = RST_WORD;
		rd_map = 1'b1;
		if (m_rd) begin
			rd_word = hold_reg[m_ridx];
		end else begin
			case (s_axi_araddr)
				OFF_CTRL: rd_word[CTRL_W-1:0] = ctrl_reg;
				OFF_COUNT: rd_word = count_reg;
				OFF_PRESC: rd_word = presc_reg;
				OFF_PCOUNT: rd_word = pcount;
				OFF_MCTRL: rd_word[MC_W*NUM_MATCH-1:0] = mctrl_reg;
				OFF_RELEASE: rd_word[NUM_MATCH-1:0] = rel_reg;
				OFF_OUTCTRL: begin
					rd_word[OC_DBL +: NUM_OUT] = dbl_reg;
					rd_word[OC_EN +: NUM_OUT] = oen_reg;
				end
				OFF_INT_STAT: rd_word[NUM_MATCH-1:0] = stat_reg;
				OFF_INT_CLR: rd_word = RST_WORD; // write only
				OFF_INT_EN: rd_word[NUM_MATCH-1:0] = ien_reg;
				default: rd_map = 1'b0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// software registers
	// ------------------------------------------------------------
	always_comb begin
		logic [DW-1:0] w;
		logic [DW-1:0] wd;
		w = RST_WORD;
		wd = wmerge(RST_WORD, w_data_reg, w_strb_reg);
		wr_map = 1'b1;
		ctrl_next = ctrl_reg;
		presc_next = presc_reg;
		mctrl_next = mctrl_reg;
		dbl_next = dbl_reg;
		oen_next = oen_reg;
		ien_next = ien_reg;
		hold_next = hold_reg;
		// hardware stop on match clears run
		if (any_stop) begin
			ctrl_next[CTRL_RUN] = 1'b0;
		end
		// copied values leave the release set
		rel_next = rel_reg & ~((pwm_on && cycle_wrap) ? rel_reg : '0);
		// match flags set on every hit
		stat_next = stat_reg | hit;
		if (do_wr && m_wr) begin
			hold_next[m_widx] = wmerge(hold_reg[m_widx], w_data_reg,
				w_strb_reg);
		end else if (do_wr) begin
			case (aw_addr_reg)
				OFF_CTRL: begin
					w = wmerge(DW'(ctrl_reg), w_data_reg, w_strb_reg);
					ctrl_next = w[CTRL_W-1:0];
				end
				OFF_PRESC: presc_next = wmerge(presc_reg, w_data_reg,
					w_strb_reg);
				OFF_MCTRL: begin
					w = wmerge(DW'(mctrl_reg), w_data_reg, w_strb_reg);
					mctrl_next = w[MC_W*NUM_MATCH-1:0];
				end
				OFF_RELEASE: begin
					// software set wins over the copy clear
					rel_next = rel_next | wd[NUM_MATCH-1:0];
				end
				OFF_OUTCTRL: begin
					w = wmerge({18'h0, oen_reg, 2'h0, dbl_reg}, w_data_reg,
						w_strb_reg);
					dbl_next = w[OC_DBL +: NUM_OUT];
					oen_next = w[OC_EN +: NUM_OUT];
				end
				OFF_INT_CLR: begin
					// a hit in the clearing cycle survives
					stat_next = (stat_reg & ~wd[NUM_MATCH-1:0]) | hit;
				end
				OFF_INT_EN: begin
					w = wmerge(DW'(ien_reg), w_data_reg, w_strb_reg);
					ien_next = w[NUM_MATCH-1:0];
				end
				OFF_COUNT, OFF_PCOUNT, OFF_INT_STAT: wr_map = 1'b1;
				default: wr_map = 1'b0;
			endcase
		end else begin
			wr_map = m_wr || (aw_addr_reg <= OFF_INT_EN);
		end
	end

	// register software state, all zero after reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= '0;
			presc_reg <= RST_WORD;
			mctrl_reg <= '0;
			rel_reg <= '0;
			dbl_reg <= '0;
			oen_reg <= '0;
			stat_reg <= '0;
			ien_reg <= '0;
			for (int i = 0; i < NUM_MATCH; i++) begin
				hold_reg[i] <= RST_WORD;
			end
		end else begin
			ctrl_reg <= ctrl_next;
			presc_reg <= presc_next;
			mctrl_reg <= mctrl_next;
			rel_reg <= rel_next;
			dbl_reg <= dbl_next;
			oen_reg <= oen_next;
			stat_reg <= stat_next;
			ien_reg <= ien_next;
			hold_reg <= hold_next;
		end
	end

	// interrupt: any enabled sticky flag
	assign irq = |(stat_reg & ien_reg);

	// ------------------------------------------------------------
	// prescaler and counter
	// ------------------------------------------------------------
	mpt_prescale #(
		.W(DW)
	) u_presc (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(ctrl_reg[CTRL_RUN]),
		.clear(crst),
		.limit(presc_reg),
		.tick(tick),
		.pcount(pcount)
	);

	// compare every match against the full counter
	for (genvar i = 0; i < NUM_MATCH; i++) begin : g_match
		assign hit[i] = tick && (count_reg == act_reg[i]);
		assign rst_en[i] = mctrl_reg[MC_W*i+MC_RST] ||
			((i == 0) && pwm_on);
		assign stop_en[i] = mctrl_reg[MC_W*i+MC_STOP];
	end
	assign any_rst = |(hit & rst_en);
	assign any_stop = |(hit & stop_en);
	assign cycle_wrap = hit[0] && rst_en[0];

	// counter steps once per tick; period is match0 plus one counts
	always_comb begin
		count_next = count_reg;
		if (crst) begin
			count_next = RST_WORD;
		end else if (any_rst) begin
			count_next = RST_WORD;
		end else if (tick) begin
			count_next = count_reg + 32'h0000_0001;
		end
		// timer mode uses values at once; pwm mode waits for the wrap
		for (int i = 0; i < NUM_MATCH; i++) begin
			act_next[i] = act_reg[i];
			if (!pwm_on) begin
				act_next[i] = hold_reg[i];
			end else if (cycle_wrap && rel_reg[i]) begin
				act_next[i] = hold_reg[i];
			end
		end
	end

	// register timer state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_reg <= RST_WORD;
			for (int i = 0; i < NUM_MATCH; i++) begin
				act_reg[i] <= RST_WORD;
			end
		end else begin
			count_reg <= count_next;
			act_reg <= act_next;
		end
	end

	// ------------------------------------------------------------
	// pwm outputs
	// ------------------------------------------------------------
	// output n: single edge rises on match0 and falls on match n;
	// double edge rises on match n-1 and falls on match n
	for (genvar n = 1; n <= NUM_OUT; n++) begin : g_out
		mpt_pwm_chan u_chan (
			.aclk(aclk),
			.aresetn(aresetn),
			.enable(pwm_on && oen_reg[n-1]),
			.set_evt(dbl_reg[n-1] ? hit[n-1] : hit[0]),
			.clr_evt(hit[n]),
			.pin(pwm_out[n-1])
		);
	end
endmodule
`default_nettype wire

// [tb/mpt_pin_load.sv]
/*
 * far-side load on the pwm pins: tallies high cycles and rising edges
 * of every pin while win is high; clr zeroes the tallies.
 * assumes the pins are registered on aclk.
 */
`timescale 1ns/1ns
`default_nettype none
module mpt_pin_load (
	input wire logic aclk,
	input wire logic clr,
	input wire logic win,
	input wire logic [5:0] pins,
	output logic [5:0][15:0] hi,
	output logic [5:0][7:0] rises
);
	logic [5:0] last_q; // pin levels one cycle back
	// a passive load: it only watches, it never shapes the pins
	always_ff @(posedge aclk) begin
		last_q <= pins;
		for (int k = 0; k < 6; k++) begin
			if (clr) begin
				hi[k] <= '0;
				rises[k] <= '0;
			end else if (win) begin
				hi[k] <= hi[k] + 16'(pins[k]);
				rises[k] <= rises[k] + 8'(pins[k] & !last_q[k]);
			end
		end
	end
endmodule
`default_nettype wire

// [tb/mpt_properties.sv]
/*
 * checker of the pwm timer top ports: reset state, bus handshakes,
 * pin and interrupt masking.
 * assumes full-word writes, so a shadow of ctrl and int_en suffices.
 */
`timescale 1ns/1ns
`default_nettype none
module mpt_properties (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [mpt_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [mpt_pkg::DW-1:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [mpt_pkg::DW-1:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [mpt_pkg::NUM_OUT-1:0] pwm_out,
	input wire logic irq
);
	import mpt_pkg::*;
	logic [7:0] a_q; // last write address taken
	logic [31:0] d_q; // last write data taken
	logic bv_q; // bvalid one cycle back
	logic pwm_sh; // shadow of the pwm mode bit
	logic en_sh; // shadow: any interrupt enabled
	// shadows commit once the write answer shows, never earlier
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bv_q <= 1'b0;
			pwm_sh <= 1'b0;
			en_sh <= 1'b0;
		end else begin
			bv_q <= s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) a_q <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready) d_q <= s_axi_wdata;
			if (s_axi_bvalid && !bv_q && a_q == OFF_CTRL) pwm_sh <= d_q[CTRL_PWM];
			if (s_axi_bvalid && !bv_q && a_q == OFF_INT_EN) en_sh <= |d_q[6:0];
		end
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	AST_RST_OUT: assert property (disable iff (1'b0)
		!aresetn |=> pwm_out == '0 && !irq) else $error("pins not cleared");
	AST_RST_BUS: assert property (disable iff (1'b0)
		!aresetn |=> !s_axi_bvalid && !s_axi_rvalid && s_axi_arready)
		else $error("bus not idle in reset");
	AST_START_LOW: assert property ($rose(aresetn) |-> (pwm_out == '0) [*2])
		else $error("pins rose right after reset");
	AST_PWM_OFF: assert property (!pwm_sh && !s_axi_bvalid |=> pwm_out == '0)
		else $error("pins driven in timer mode");
	AST_IRQ_MASK: assert property (!en_sh && !s_axi_bvalid |-> !irq)
		else $error("irq with all enables off");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
	AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	AST_R_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready && !s_axi_bvalid |-> ##2 s_axi_bvalid)
		else $error("write answer late");
endmodule
bind mpt_top mpt_properties u_props (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .pwm_out(pwm_out), .irq(irq)
);
`default_nettype wire

// [tb/multi_channel_pwm_timer_bench.sv]
/*
 * bench of the pwm timer: random match layouts, release timing,
 * interrupts, stop on match and bus errors.
 * assumes mpt_top, the pin load and the checker are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
$display("wrong value %s exp %0h got %0h", nm, e, g); end end
module multi_channel_pwm_timer_bench;
	import mpt_pkg::*;
	logic aclk = 0, aresetn = 0, clr = 0, win = 0, irq;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv, rv2;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready;
	logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [5:0] pwm_out, dbl;
	logic [5:0][15:0] hi;
	logic [5:0][7:0] rises;
	int err_count = 0, checks = 0, seed = 11;
	int m[7], nm[7], h[6], p, per, it, n;
	always #5 aclk = ~aclk;
	mpt_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .pwm_out(pwm_out), .irq(irq));
	mpt_pin_load u_load (.aclk(aclk), .clr(clr), .win(win), .pins(pwm_out),
		.hi(hi), .rises(rises));
	// ----------------------------------------------------------
	// bus tasks
	// ----------------------------------------------------------
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic tmo(input int k);
		if (k >= 60) begin
			err_count++;
			$display("wrong value wait limit exp 0 got %0d", k);
			wrap_up;
		end
	endtask
	// answer stalls a random 0..2 cycles on the ready side
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int k, dl;
		dl = $unsigned($random(seed)) % 3;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= (dl == 0);
		k = 0;
		do begin
			@(posedge aclk);
			k++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (k == dl) s_axi_bready <= 1'b1;
		end while (!(s_axi_bvalid && s_axi_bready) && k < 60);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		tmo(k);
	endtask
	task automatic rd(input logic [7:0] a);
		int k, dl;
		dl = $unsigned($random(seed)) % 3;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= (dl == 0);
		k = 0;
		do begin
			@(posedge aclk);
			k++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (k == dl) s_axi_rready <= 1'b1;
		end while (!(s_axi_rvalid && s_axi_rready) && k < 60);
		rv = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		tmo(k);
	endtask
	// high time of a pin per cycle: fall match minus rise match, wrapped
	function automatic int hexp(int k);
		int r;
		r = dbl[k] ? m[k] : m[0];
		return ((m[k+1] - r + m[0] + 1) % (m[0] + 1)) * (p + 1);
	endfunction
	// one full period through the load, against h and per
	task automatic measure;
		@(posedge aclk);
		clr <= 1'b1;
		@(posedge aclk);
		clr <= 1'b0;
		win <= 1'b1;
		repeat (per) @(posedge aclk);
		win <= 1'b0;
		@(posedge aclk);
		for (int k = 0; k < 6; k++) begin
			`CHK("high time", 16'(h[k]), hi[k])
			`CHK("rise count", 8'(h[k] != 0), rises[k])
		end
	endtask
	// ----------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rd(OFF_CTRL);
		`CHK("ctrl", 32'h0, rv)
		rd(OFF_PCOUNT);
		`CHK("prescale count", 32'h0, rv)
		rd(8'h30);
		`CHK("unmapped read", RESP_SLVERR, resp)
		wr(8'h34, 32'h1);
		`CHK("unmapped write", RESP_SLVERR, resp)
		$display("test reset and map done");
		p = $unsigned($random(seed)) % 3;
		wr(OFF_PRESC, p);
		// single, double and mixed layouts; corners forced in each
		for (it = 0; it < 3; it++) begin
			nm[0] = 3 + $unsigned($random(seed)) % 6;
			for (n = 1; n < 7; n++) nm[n] = $unsigned($random(seed)) % nm[0];
			if (it == 0) nm[1] = 0;
			if (it == 1) nm[4] = nm[3];
			if (it == 2) nm[2] = nm[0] - 1;
			if (it == 2) nm[3] = 0;
			for (n = 0; n < 7; n++) wr(OFF_MATCH0 + 8'(4 * n), nm[n]);
			if (it > 0) measure;
			m = nm;
			dbl = (it == 0) ? 6'h00 : (it == 1) ? 6'h2a : 6'h15;
			per = (m[0] + 1) * (p + 1);
			for (n = 0; n < 6; n++) h[n] = hexp(n);
			wr(OFF_OUTCTRL, {18'h0, 6'h3f, 2'h0, dbl});
			wr(OFF_RELEASE, 32'h7f);
			wr(OFF_CTRL, 32'h5);
			n = 0;
			do begin
				rd(OFF_RELEASE);
				n++;
			end while (rv[6:0] !== 7'h0 && n < 60);
			tmo(n);
			repeat (per) @(posedge aclk);
			measure;
			$display("test layout %0d done", it);
		end
		wr(OFF_INT_CLR, 32'h7f);
		wr(OFF_INT_EN, 32'h1);
		repeat (per + 2) @(posedge aclk);
		`CHK("irq raised", 1'b1, irq)
		rd(OFF_INT_STAT);
		`CHK("cycle flag", 1'b1, rv[0])
		wr(OFF_INT_EN, 32'h0);
		`CHK("irq masked", 1'b0, irq)
		$display("test interrupt done");
		wr(OFF_CTRL, 32'h2);
		wr(OFF_MCTRL, 32'h20);
		wr(OFF_MATCH0 + 8'h8, 32'h5);
		wr(OFF_CTRL, 32'h1);
		repeat (40) @(posedge aclk);
		`CHK("pins in timer mode", 6'h0, pwm_out)
		rd(OFF_CTRL);
		`CHK("run after stop", 32'h0, rv)
		rd(OFF_COUNT);
		rv2 = rv;
		rd(OFF_COUNT);
		`CHK("count held", rv2, rv)
		// reset on match 2 in timer mode keeps the count within 0..5
		wr(OFF_CTRL, 32'h2);
		wr(OFF_MCTRL, 32'h10);
		wr(OFF_CTRL, 32'h1);
		repeat (40) @(posedge aclk);
		rd(OFF_COUNT);
		`CHK("count wrapped", 1'b1, rv <= 32'h5)
		$display("test stop on match done");
		wrap_up;
	end
endmodule
`default_nettype wire
